// ### verilog/sbs_pkg.sv
package sbs_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WREG  = 8'h04;
  localparam logic [7:0] OFF_STAT  = 8'h08;
  localparam logic [7:0] OFF_BSR   = 8'h0C;
  localparam logic [7:0] OFF_FSR   = 8'h10;
  localparam logic [7:0] OFF_CTRL  = 8'h14;
  localparam logic [7:0] OFF_WDT   = 8'h18;
  localparam logic [7:0] OFF_MADDR = 8'h1C;
  localparam logic [7:0] OFF_MDATA = 8'h20;
  localparam logic [7:0] OFF_STATE = 8'h24;

  // ==========================================================
  // Field positions
  localparam int ST_PD   = 5;
  localparam int ST_TO   = 6;
  localparam int CT_EXT  = 0;
  localparam int CT_WDT  = 1;
  localparam int CT_WAKE = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic       RST_TO   = 1'b1;
  localparam logic       RST_PD   = 1'b1;

  // ==========================================================
  // Opcodes and constants
  localparam logic [15:0] OP_SLEEP    = 16'h0003;
  localparam logic [5:0]  OP_SUB      = 6'b010101;
  localparam logic [7:0]  ACC_LIMIT   = 8'h5F;
  localparam logic [7:0]  WDT_CLR     = 8'h00;
  localparam logic [15:0] WDT_POST_DF = 16'h0080;

  // ==========================================================
  // Types
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } sbs_flags_t;

  typedef struct packed {
    logic [7:0] res;
    sbs_flags_t fl;
  } sbs_alu_t;

  typedef enum logic [2:0] {
    Q_IDLE = 3'b000,
    Q_1    = 3'b001,
    Q_2    = 3'b010,
    Q_3    = 3'b011,
    Q_4    = 3'b100
  } sbs_q_t;

endpackage : sbs_pkg

// ### verilog/sbs_exec.sv
`timescale 1ns/1ps
module sbs_exec
  import sbs_pkg::*;
#(
  parameter int          BSR_W    = 4,
  parameter logic [15:0] WDT_POST = WDT_POST_DF
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             osc_stopped
);

  localparam int AW = 8 + BSR_W;

  // ==========================================================
  // State
  logic [7:0]       mem [0:(1<<AW)-1];
  sbs_q_t           q_ff;
  logic [15:0]      ir_ff;
  logic [AW-1:0]    addr_ff;
  logic [7:0]       opnd_ff;
  sbs_alu_t         alu_ff;
  logic [7:0]       wreg_ff;
  sbs_flags_t       stat_ff;
  logic             to_ff;
  logic             pd_ff;
  logic [BSR_W-1:0] bsr_ff;
  logic [AW-1:0]    fsr_ff;
  logic [1:0]       ctrl_ff;
  logic [15:0]      post_ff;
  logic [7:0]       wdt_ff;
  logic [AW-1:0]    maddr_ff;
  logic             asleep_ff;
  logic [31:0]      prdata_ff;
  logic             pready_ff;
  logic             pslverr_ff;

  // ==========================================================
  // Subtract with borrow
  function automatic sbs_alu_t sub_calc(input logic [7:0] w, input logic [7:0] f, input logic c);
    logic [8:0] full;
    logic [4:0] low;
    sbs_alu_t   r;
    full     = {1'b0, w} + {1'b0, ~f} + {8'h00, c};
    low      = {1'b0, w[3:0]} + {1'b0, ~f[3:0]} + {4'h0, c};
    r.res    = full[7:0];
    r.fl.c   = full[8];
    r.fl.dc  = low[4];
    r.fl.z   = (full[7:0] == 8'h00);
    r.fl.n   = full[7];
    r.fl.ov  = (w[7] != f[7]) && (full[7] != w[7]);
    return r;
  endfunction : sub_calc

  // ==========================================================
  // Instruction decode
  wire         is_sleep_w = (ir_ff == OP_SLEEP);
  wire         is_sub_w   = (ir_ff[15:10] == OP_SUB);
  wire         dst_f_w    = ir_ff[9];
  wire         acc_a_w    = ir_ff[8];
  wire [7:0]   fop_w      = ir_ff[7:0];
  wire         low_f_w    = (fop_w <= ACC_LIMIT);
  wire         idx_w      = !acc_a_w && ctrl_ff[CT_EXT] && low_f_w;
  wire [AW-1:0] ind_ea_w  = fsr_ff + {{BSR_W{1'b0}}, fop_w};
  wire [AW-1:0] acc_ea_w  = {{BSR_W{!low_f_w}}, fop_w};
  wire [AW-1:0] bank_ea_w = {bsr_ff, fop_w};
  wire [AW-1:0] ea_w      = idx_w ? ind_ea_w : (acc_a_w ? bank_ea_w : acc_ea_w);

  // ==========================================================
  // Watchdog
  wire post_wrap_w = (post_ff == WDT_POST - 16'h0001);
  wire wdt_ovf_w   = ctrl_ff[CT_WDT] && post_wrap_w && (wdt_ff == 8'hFF);
  wire sleep_q4_w  = (q_ff == Q_4) && is_sleep_w;
  wire sub_q4_w    = (q_ff == Q_4) && is_sub_w;

  // ==========================================================
  // APB decode
  wire       access_w = psel && penable;
  wire       done_w   = access_w && pready_ff;
  wire       busy_w   = (q_ff != Q_IDLE);
  wire       hit_w    = (paddr == OFF_INSTR) || (paddr == OFF_WREG) || (paddr == OFF_STAT)
                     || (paddr == OFF_BSR) || (paddr == OFF_FSR) || (paddr == OFF_CTRL)
                     || (paddr == OFF_WDT) || (paddr == OFF_MADDR) || (paddr == OFF_MDATA)
                     || (paddr == OFF_STATE);
  wire       wr_bad_w = pwrite && (busy_w || (asleep_ff && paddr == OFF_INSTR));
  wire       err_w    = !hit_w || wr_bad_w;
  wire       wr_w     = done_w && pwrite && !pslverr_ff;
  wire       wr_instr = wr_w && (paddr == OFF_INSTR);
  wire       wr_ctrl  = wr_w && (paddr == OFF_CTRL);
  wire       wake_sw  = wr_ctrl && pwdata[CT_WAKE];
  wire [7:0] stat_rd  = {1'b0, to_ff, pd_ff, stat_ff.n, stat_ff.ov, stat_ff.z, stat_ff.dc, stat_ff.c};
  wire [31:0] rd_w    =
      (paddr == OFF_INSTR) ? {16'h0000, ir_ff} :
      (paddr == OFF_WREG)  ? {24'h00_0000, wreg_ff} :
      (paddr == OFF_STAT)  ? {24'h00_0000, stat_rd} :
      (paddr == OFF_BSR)   ? 32'(bsr_ff) :
      (paddr == OFF_FSR)   ? 32'(fsr_ff) :
      (paddr == OFF_CTRL)  ? {30'h0, ctrl_ff} :
      (paddr == OFF_WDT)   ? {8'h00, post_ff, wdt_ff} :
      (paddr == OFF_MADDR) ? 32'(maddr_ff) :
      (paddr == OFF_MDATA) ? {24'h00_0000, mem[maddr_ff]} :
      (paddr == OFF_STATE) ? {27'h0, asleep_ff, busy_w, q_ff} :
                             32'h0000_0000;

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign osc_stopped = asleep_ff;

  // ==========================================================
  // APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= access_w && !pready_ff;
      if (access_w && !pready_ff)
      begin
        pslverr_ff <= err_w;
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_w;
      end
      else if (!access_w)
      begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Quarter-cycle sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_ff    <= Q_IDLE;
      ir_ff   <= 16'h0000;
      addr_ff <= '0;
      opnd_ff <= 8'h00;
      alu_ff  <= '0;
    end
    else
    begin
      unique case (q_ff)
        Q_IDLE:
        begin
          if (wr_instr)
          begin
            ir_ff <= pwdata[15:0];
            q_ff  <= Q_1;
          end
        end
        Q_1:
        begin
          addr_ff <= ea_w;
          q_ff    <= Q_2;
        end
        Q_2:
        begin
          opnd_ff <= mem[addr_ff];
          q_ff    <= Q_3;
        end
        Q_3:
        begin
          alu_ff <= sub_calc(wreg_ff, opnd_ff, stat_ff.c);
          q_ff   <= Q_4;
        end
        Q_4:
        begin
          q_ff <= Q_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Architectural registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wreg_ff   <= RST_WREG;
      stat_ff   <= '0;
      to_ff     <= RST_TO;
      pd_ff     <= RST_PD;
      bsr_ff    <= '0;
      fsr_ff    <= '0;
      ctrl_ff   <= RST_CTRL;
      maddr_ff  <= '0;
      asleep_ff <= 1'b0;
    end
    else
    begin
      if (sub_q4_w)
      begin
        stat_ff <= alu_ff.fl;
        if (!dst_f_w)
        begin
          wreg_ff <= alu_ff.res;
        end
      end
      if (sleep_q4_w)
      begin
        pd_ff     <= 1'b0;
        to_ff     <= 1'b1;
        asleep_ff <= 1'b1;
      end
      else if (asleep_ff && wdt_ovf_w)
      begin
        to_ff     <= 1'b0;
        asleep_ff <= 1'b0;
      end
      else if (asleep_ff && wake_sw)
      begin
        asleep_ff <= 1'b0;
      end
      if (wr_w && paddr == OFF_WREG)  wreg_ff  <= pwdata[7:0];
      if (wr_w && paddr == OFF_STAT)  stat_ff  <= sbs_flags_t'(pwdata[4:0]);
      if (wr_w && paddr == OFF_BSR)   bsr_ff   <= pwdata[BSR_W-1:0];
      if (wr_w && paddr == OFF_FSR)   fsr_ff   <= pwdata[AW-1:0];
      if (wr_ctrl)                    ctrl_ff  <= pwdata[1:0];
      if (wr_w && paddr == OFF_MADDR) maddr_ff <= pwdata[AW-1:0];
    end
  end

  // ==========================================================
  // Watchdog counter and postscaler
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      post_ff <= 16'h0000;
      wdt_ff  <= WDT_CLR;
    end
    else if (sleep_q4_w)
    begin
      post_ff <= 16'h0000;
      wdt_ff  <= WDT_CLR;
    end
    else if (ctrl_ff[CT_WDT])
    begin
      post_ff <= post_wrap_w ? 16'h0000 : post_ff + 16'h0001;
      if (post_wrap_w)
      begin
        wdt_ff <= wdt_ff + 8'h01;
      end
    end
  end

  // ==========================================================
  // File memory
  always_ff @(posedge pclk)
  begin
    if (sub_q4_w && dst_f_w)
    begin
      mem[addr_ff] <= alu_ff.res;
    end
    else if (wr_w && paddr == OFF_MDATA)
    begin
      mem[maddr_ff] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_pd_clear: assert property (sleep_q4_w |=> !pd_ff)
    else $error("power-down flag not cleared by halt");
  a_sleep_to_set: assert property (sleep_q4_w |=> to_ff)
    else $error("time-out flag not set by halt");
  a_sleep_wdt_zero: assert property (sleep_q4_w |=> (wdt_ff == 8'h00 && post_ff == 16'h0000))
    else $error("watchdog not cleared by halt");
  a_sleep_enter_q4: assert property ((q_ff == Q_1 && is_sleep_w && !asleep_ff)
      |=> !asleep_ff ##1 !asleep_ff ##1 !asleep_ff ##1 asleep_ff)
    else $error("halt not entered at fourth quarter");
  a_wake_to_clear: assert property ((asleep_ff && wdt_ovf_w) |=> (!to_ff && !asleep_ff))
    else $error("watchdog wake did not clear time-out");
  a_sub_w_result: assert property (sub_q4_w && !dst_f_w |=> wreg_ff == 8'($past(wreg_ff)
      - $past(opnd_ff) - {7'h00, !$past(stat_ff.c)}))
    else $error("borrow-subtract result wrong");
  a_sub_carry: assert property (sub_q4_w |=> stat_ff.c == ({1'b0, $past(wreg_ff)}
      >= {1'b0, $past(opnd_ff)} + {8'h00, !$past(stat_ff.c)}))
    else $error("borrow-subtract carry wrong");
  a_sub_one_cycle: assert property ((q_ff == Q_1 && is_sub_w) |-> ##3 q_ff == Q_4 ##1 q_ff == Q_IDLE)
    else $error("borrow-subtract not finished in one instruction cycle");
  a_sub_f_keeps_w: assert property (sub_q4_w && dst_f_w |=> $stable(wreg_ff))
    else $error("file destination changed W");
  a_access_bank: assert property ((q_ff == Q_1 && !acc_a_w && !idx_w)
      |=> addr_ff == {{BSR_W{$past(fop_w) > 8'h5F}}, $past(fop_w)})
    else $error("access bank address wrong");
  a_bsr_bank: assert property ((q_ff == Q_1 && acc_a_w) |=> addr_ff[AW-1:8] == $past(bsr_ff))
    else $error("bank select not used");
  a_indexed_off: assert property ((q_ff == Q_1 && idx_w)
      |=> addr_ff == AW'($past(fsr_ff) + AW'($past(fop_w))))
    else $error("indexed offset address wrong");
  a_decode_halt: assert property ((q_ff == Q_IDLE && wr_instr && pwdata[15:0] == 16'h0003)
      |=> is_sleep_w && !is_sub_w)
    else $error("halt word not decoded");

endmodule : sbs_exec

// ### tb/tb_sleep_and_borrow_subtract_exec.sv
`timescale 1ns/1ps
module tb_sleep_and_borrow_subtract_exec
  import sbs_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_stopped;
  int          miscompares;
  int          n_compared;
  logic [31:0] rdat;
  logic        rerr;

  sbs_exec #(.BSR_W(4), .WDT_POST(16'h0002)) uut (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .osc_stopped (osc_stopped)
  );

  // ==========================================================
  // Clock, reset and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end

  // ==========================================================
  // Shared helpers
  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    int i;
    i = 0;
    do
    begin
      apb(1'b0, OFF_STATE, 32'h0000_0000);
      i++;
    end
    while (rdat[3] !== 1'b0 && i < 20);
  endtask : wait_idle

  // Runs one borrow subtract and judges destination and flags
  task automatic do_sub(input logic [15:0] instr, input logic [11:0] addr,
                        input logic [7:0] w, input logic [7:0] f, input logic c);
    logic [8:0] full;
    logic [4:0] low;
    sbs_alu_t   e;
    full = {1'b0, w} - {1'b0, f} - {8'h00, !c};
    low  = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, !c};
    e.res   = full[7:0];
    e.fl.c  = !full[8];
    e.fl.dc = !low[4];
    e.fl.n  = full[7];
    e.fl.z  = (full[7:0] == 8'h00);
    e.fl.ov = (w[7] != f[7]) && (full[7] != w[7]);
    apb(1'b1, OFF_WREG, {24'h0000_00, w});
    apb(1'b1, OFF_STAT, {31'h0000_0000, c});
    apb(1'b1, OFF_MADDR, {20'h0_0000, addr});
    apb(1'b1, OFF_MDATA, {24'h0000_00, f});
    apb(1'b1, OFF_INSTR, {16'h0000, instr});
    wait_idle();
    apb(1'b0, instr[9] ? OFF_MDATA : OFF_WREG, 32'h0000_0000);
    check(rdat, {24'h0000_00, e.res});
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    check({27'h000_0000, rdat[4:0]}, {27'h000_0000, e.fl});
  endtask : do_sub

  // ==========================================================
  // Scenarios
  task automatic s_bank_select();
    apb(1'b1, OFF_BSR, 32'h0000_0002);
    do_sub(16'h5734, 12'h234, 8'h02, 8'h03, 1'b1);
  endtask : s_bank_select

  task automatic s_access_low();
    apb(1'b1, OFF_BSR, 32'h0000_0005);
    do_sub(16'h5420, 12'h020, 8'h05, 8'h02, 1'b1);
    do_sub(16'h5420, 12'h020, 8'h02, 8'h02, 1'b1);
  endtask : s_access_low

  task automatic s_access_top();
    do_sub(16'h5480, 12'hF80, 8'h80, 8'h01, 1'b1);
    do_sub(16'h5480, 12'hF80, 8'h7F, 8'hFF, 1'b0);
  endtask : s_access_top

  task automatic s_indexed();
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    apb(1'b1, OFF_FSR, 32'h0000_0100);
    do_sub(16'h5410, 12'h110, 8'h02, 8'h02, 1'b0);
    do_sub(16'h545F, 12'h15F, 8'h18, 8'h09, 1'b1);
    do_sub(16'h5460, 12'hF60, 8'h10, 8'h01, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
  endtask : s_indexed

  task automatic s_unmapped();
    apb(1'b0, 8'h28, 32'h0000_0000);
    check({31'h0000_0000, rerr}, 32'h0000_0001);
  endtask : s_unmapped

  task automatic s_halt_wake();
    int i;
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    repeat (300) @(posedge pclk);
    apb(1'b1, OFF_INSTR, {16'h0000, OP_SLEEP});
    repeat (4) @(posedge pclk);
    check({31'h0000_0000, osc_stopped}, 32'h0000_0000);
    #1;
    check({31'h0000_0000, osc_stopped}, 32'h0000_0001);
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    check({31'h0000_0000, rdat[5]}, 32'h0000_0000);
    check({31'h0000_0000, rdat[6]}, 32'h0000_0001);
    apb(1'b0, OFF_WDT, 32'h0000_0000);
    check({31'h0000_0000, rdat < 32'h0000_0200 && rdat[7:0] < 8'h20}, 32'h0000_0001);
    apb(1'b1, OFF_INSTR, 32'h0000_0003);
    check({31'h0000_0000, rerr}, 32'h0000_0001);
    i = 0;
    while (osc_stopped === 1'b1 && i < 800)
    begin
      @(posedge pclk);
      i++;
    end
    check({31'h0000_0000, osc_stopped}, 32'h0000_0000);
    apb(1'b0, OFF_STAT, 32'h0000_0000);
    check({31'h0000_0000, rdat[6]}, 32'h0000_0000);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
  endtask : s_halt_wake

  // ==========================================================
  // Main sequence
  initial
  begin
    miscompares = 0;
    n_compared  = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_bank_select();
    s_access_low();
    s_access_top();
    s_indexed();
    s_unmapped();
    s_halt_wake();
    end_of_test();
  end
endmodule : tb_sleep_and_borrow_subtract_exec
